// file: ram_waveform_playback.sv
/*
 * Waveform RAM playback controller. Picks one of eight profiles from the
 * profile pins, reads the 1024 x 32 RAM, routes each word to frequency,
 * phase, amplitude or polar phase and amplitude, and runs direct switch (with optional zero crossing)
 * and ramp-up playback with a sweep-done output.
 * Assumes a RAM read port with one cycle of latency, profile fields on flat
 * input buses (profile n at slice n), and a phase accumulator wrap pulse.
 */
`default_nettype none

module ram_waveform_playback (
    input wire logic clk_i,                                           // system clock, 200 MHz
    input wire logic srst_i,                                          // synchronous reset, high
    input wire logic ram_enable_i,                                    // RAM enable control bit
    input wire logic io_update_i,                                     // I/O update pulse
    input wire logic serial_ram_access_i,                             // serial port is using RAM
    input wire logic [ram_playback_pkg::PROF_W-1:0] profile_i,        // profile select pins
    input wire logic [31:0] first_control_register_i,                 // holds destination field
    input wire logic [ram_playback_pkg::PROF_N*ram_playback_pkg::ADDR_W-1:0] start_addr_i, // starts
    input wire logic [ram_playback_pkg::PROF_N*ram_playback_pkg::ADDR_W-1:0] end_addr_i,   // ends
    input wire logic [ram_playback_pkg::PROF_N*ram_playback_pkg::RATE_W-1:0] step_rate_i,  // rates
    input wire logic [ram_playback_pkg::PROF_N*ram_playback_pkg::MODE_W-1:0] mode_i,       // modes
    input wire logic [ram_playback_pkg::PROF_N-1:0] no_dwell_i,       // no-dwell bit per profile
    input wire logic [ram_playback_pkg::PROF_N-1:0] zero_cross_i,     // zero-crossing bit per profile
    input wire logic [31:0] frequency_tuning_word_i,                  // frequency register
    input wire logic [ram_playback_pkg::PHASE_W-1:0] phase_offset_word_i,     // phase register
    input wire logic [ram_playback_pkg::AMP_W-1:0] amplitude_scale_factor_i,  // amplitude register
    input wire logic phase_wrap_i,                                    // accumulator wrapped to zero
    input wire logic [ram_playback_pkg::DATA_W-1:0] ram_data_i,       // RAM read data
    output logic [ram_playback_pkg::ADDR_W-1:0] ram_addr_o,           // RAM read address
    output logic ram_rd_o,                                            // RAM read strobe
    output logic [31:0] freq_o,                                       // frequency to the core
    output logic [ram_playback_pkg::PHASE_W-1:0] phase_o,             // phase to the core
    output logic [ram_playback_pkg::AMP_W-1:0] amp_o,                 // amplitude to the core
    output logic sweep_done_out_o,                                    // end of playback sequence
    output logic playing_o,                                           // direct or ramp in progress
    output logic unsupported_mode_o                                   // profile mode not sequenced here
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        ram_playback_pkg::play_state_t st;
        logic [ram_playback_pkg::PROF_W-1:0] prof_q1;
        logic [ram_playback_pkg::PROF_W-1:0] prof_q2;
        logic [ram_playback_pkg::PROF_W-1:0] prof_last;
        logic [ram_playback_pkg::PROF_W-1:0] prof;
        logic ram_en;
        logic [ram_playback_pkg::ADDR_W-1:0] addr;
        logic rd_q;
        logic [ram_playback_pkg::DATA_W-1:0] word;
        logic word_vld;
        logic [ram_playback_pkg::DATA_W-1:0] applied;
        logic applied_vld;
        logic sweep;
        logic unsup;
        logic [31:0] freq;
        logic [ram_playback_pkg::PHASE_W-1:0] phase;
        logic [ram_playback_pkg::AMP_W-1:0] amp;
    } play_regs_t;

    play_regs_t s_r;
    play_regs_t s_nxt;

    logic [ram_playback_pkg::ADDR_W-1:0] sel_start;
    logic [ram_playback_pkg::ADDR_W-1:0] sel_end;
    logic [ram_playback_pkg::RATE_W-1:0] sel_rate;
    logic [ram_playback_pkg::MODE_W-1:0] sel_mode;
    logic sel_no_dwell;
    logic sel_zero_cross;
    logic [1:0] dest;
    logic prof_change;
    logic start_evt;
    logic timer_restart;
    logic timer_run;
    logic step_expire;
    logic zc_hold;

    ////////////////////////////////////////////////////////////////////////////
    // functions

    // mode field to playback mode
    function automatic ram_playback_pkg::mode_kind_t decode_mode(
        input logic [ram_playback_pkg::MODE_W-1:0] code
    );
        case (code)
            ram_playback_pkg::MODE_RAMP_UP: decode_mode = ram_playback_pkg::MK_RAMP_UP;
            ram_playback_pkg::MODE_BIDIR: decode_mode = ram_playback_pkg::MK_BIDIR;
            ram_playback_pkg::MODE_CONT_BIDIR: decode_mode = ram_playback_pkg::MK_CONT_BIDIR;
            ram_playback_pkg::MODE_RECIRC: decode_mode = ram_playback_pkg::MK_RECIRC;
            default: decode_mode = ram_playback_pkg::MK_DIRECT;      // 000, 101, 110, 111
        endcase
    endfunction : decode_mode

    // true for the modes whose sequencing lives elsewhere
    function automatic logic mode_unsupported(input ram_playback_pkg::mode_kind_t mk);
        mode_unsupported = (mk == ram_playback_pkg::MK_BIDIR) ||
                           (mk == ram_playback_pkg::MK_CONT_BIDIR) ||
                           (mk == ram_playback_pkg::MK_RECIRC);
    endfunction : mode_unsupported

    ////////////////////////////////////////////////////////////////////////////
    // fields of the active profile; the index is latched at each start, and a
    // pin change leaving the sync chain starts again with the new profile

    assign sel_start = start_addr_i[s_r.prof*ram_playback_pkg::ADDR_W +: ram_playback_pkg::ADDR_W];
    assign sel_end = end_addr_i[s_r.prof*ram_playback_pkg::ADDR_W +: ram_playback_pkg::ADDR_W];
    assign sel_rate = step_rate_i[s_r.prof*ram_playback_pkg::RATE_W +: ram_playback_pkg::RATE_W];
    assign sel_no_dwell = no_dwell_i[s_r.prof];
    assign sel_zero_cross = zero_cross_i[s_r.prof];
    // the new profile's mode is read straight from the synchronised pins at a start
    assign sel_mode = mode_i[s_r.prof_q2*ram_playback_pkg::MODE_W +: ram_playback_pkg::MODE_W];
    assign dest = first_control_register_i[ram_playback_pkg::DEST_HI:ram_playback_pkg::DEST_LO];

    // change seen on the synchronised pins, in the same cycle the second stage shows it
    assign prof_change = (s_r.prof_q2 != s_r.prof_last);
    // serial access has priority: starts are not taken while it runs
    assign start_evt = (io_update_i || prof_change) && !serial_ram_access_i;

    // zero crossing only holds phase in direct mode with phase destination
    assign zc_hold = sel_zero_cross && (dest == ram_playback_pkg::DEST_PHASE) &&
                     (s_r.st == ram_playback_pkg::ST_DIRECT);

    // timer restarts at every start and counts only while ramping
    assign timer_restart = start_evt;
    assign timer_run = (s_r.st == ram_playback_pkg::ST_RAMP);

    ////////////////////////////////////////////////////////////////////////////
    // step timer

    ram_step_timer u_step_timer (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .restart_i(timer_restart),
        .run_i(timer_run),
        .rate_i(sel_rate),
        .expire_o(step_expire)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        ram_playback_pkg::mode_kind_t mk;
        s_nxt = s_r;
        mk = ram_playback_pkg::MK_DIRECT;

        // two-stage sync of the profile pins, then the compare stage
        s_nxt.prof_q1 = profile_i;
        s_nxt.prof_q2 = s_r.prof_q1;
        s_nxt.prof_last = s_r.prof_q2;
        if (start_evt) begin
            s_nxt.prof = s_r.prof_q2;
        end

        // read data arrives one cycle after the strobe
        s_nxt.rd_q = ram_rd_o && !start_evt;                            // a start drops the old address's read
        s_nxt.word_vld = s_r.rd_q;
        if (s_r.rd_q) begin
            s_nxt.word = ram_data_i;
        end

        // controller
        if (serial_ram_access_i) begin
            // an interrupted waveform is not resumed, it waits for a new start
            s_nxt.st = ram_playback_pkg::ST_SUSPEND;
            s_nxt.applied_vld = 1'b0;
            s_nxt.word_vld = 1'b0;
            s_nxt.sweep = 1'b0;
        end else if (start_evt) begin
            s_nxt.ram_en = ram_enable_i;
            mk = decode_mode(sel_mode);
            s_nxt.unsup = ram_enable_i && mode_unsupported(mk);
            s_nxt.addr = start_addr_i[s_r.prof_q2*ram_playback_pkg::ADDR_W +: ram_playback_pkg::ADDR_W];
            s_nxt.sweep = 1'b0;
            s_nxt.word_vld = 1'b0;
            if (!ram_enable_i) begin
                s_nxt.st = ram_playback_pkg::ST_IDLE;
                s_nxt.applied_vld = 1'b0;
            end else begin
                case (mk)
                    ram_playback_pkg::MK_DIRECT: begin
                        s_nxt.st = ram_playback_pkg::ST_DIRECT;
                    end
                    ram_playback_pkg::MK_RAMP_UP: begin
                        s_nxt.st = ram_playback_pkg::ST_RAMP;
                    end
                    default: begin
                        s_nxt.st = ram_playback_pkg::ST_IDLE;
                        s_nxt.applied_vld = 1'b0;
                    end
                endcase
            end
        end else begin
            case (s_r.st)
                ram_playback_pkg::ST_DIRECT: begin
                    // address never moves; sweep stays low, no-dwell unused
                    s_nxt.sweep = 1'b0;
                end
                ram_playback_pkg::ST_RAMP: begin
                    if (step_expire) begin
                        if (s_r.addr == sel_end) begin
                            // no-dwell goes back to start; otherwise stay at end
                            if (sel_no_dwell) begin
                                s_nxt.addr = sel_start;
                            end
                            s_nxt.st = ram_playback_pkg::ST_DONE;
                            s_nxt.sweep = 1'b1;
                        end else begin
                            s_nxt.addr = s_r.addr + 10'h001;
                            if (s_nxt.addr == sel_end && !sel_no_dwell) begin
                                s_nxt.st = ram_playback_pkg::ST_DONE;
                                s_nxt.sweep = 1'b1;
                            end
                        end
                    end
                end
                ram_playback_pkg::ST_DONE: begin
                    s_nxt.st = ram_playback_pkg::ST_DONE;
                end
                ram_playback_pkg::ST_SUSPEND: begin
                    s_nxt.st = ram_playback_pkg::ST_IDLE;
                end
                default: begin
                    s_nxt.st = ram_playback_pkg::ST_IDLE;
                end
            endcase
        end

        // the fetched word is applied at once, or at wrap under zero crossing
        if (!serial_ram_access_i && !start_evt && s_r.word_vld) begin
            if (!zc_hold || phase_wrap_i) begin
                s_nxt.applied = s_r.word;
                s_nxt.applied_vld = 1'b1;
            end
        end

        // sweep flag forced low whenever the enable latched at the last start is low
        if (!s_nxt.ram_en) begin
            s_nxt.sweep = 1'b0;
        end

        // parameters default to their registers
        s_nxt.freq = frequency_tuning_word_i;
        s_nxt.phase = phase_offset_word_i;
        s_nxt.amp = amplitude_scale_factor_i;
        if (s_r.ram_en && s_r.applied_vld) begin
            // low bits outside each slice are simply not looked at
            case (dest)
                ram_playback_pkg::DEST_FREQ: begin
                    s_nxt.freq = s_r.applied;
                end
                ram_playback_pkg::DEST_PHASE: begin
                    s_nxt.phase = s_r.applied[ram_playback_pkg::PHASE_HI:ram_playback_pkg::PHASE_LO];
                end
                ram_playback_pkg::DEST_AMP: begin
                    s_nxt.amp = s_r.applied[ram_playback_pkg::AMP_HI:ram_playback_pkg::AMP_LO];
                end
                default: begin
                    s_nxt.phase = s_r.applied[ram_playback_pkg::PHASE_HI:ram_playback_pkg::PHASE_LO];
                    s_nxt.amp = s_r.applied[ram_playback_pkg::POLAR_AMP_HI:ram_playback_pkg::POLAR_AMP_LO];
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_r <= '0;
            s_r.st <= ram_playback_pkg::ST_IDLE;
            s_r.addr <= ram_playback_pkg::ADDR_RST;
            s_r.word <= ram_playback_pkg::WORD_RST;
            s_r.applied <= ram_playback_pkg::WORD_RST;
            s_r.prof <= ram_playback_pkg::PROF_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // RAM is read every cycle while a waveform is live; the serial port owns it otherwise
    assign ram_rd_o = !serial_ram_access_i &&
                      ((s_r.st == ram_playback_pkg::ST_DIRECT) ||
                       (s_r.st == ram_playback_pkg::ST_RAMP) ||
                       (s_r.st == ram_playback_pkg::ST_DONE));
    assign ram_addr_o = s_r.addr;
    assign freq_o = s_r.freq;
    assign phase_o = s_r.phase;
    assign amp_o = s_r.amp;
    assign sweep_done_out_o = s_r.sweep;
    assign playing_o = (s_r.st == ram_playback_pkg::ST_DIRECT) ||
                       (s_r.st == ram_playback_pkg::ST_RAMP);
    assign unsupported_mode_o = s_r.unsup;

endmodule : ram_waveform_playback

`default_nettype wire

// file: ram_playback_pkg.sv
/*
 * Shared constants and types for the waveform RAM playback controller:
 * widths, field positions, destination and mode encodings, controller states
 * and the DDS clock division.
 * Assumes one 200 MHz system clock and a DDS clock of one quarter of it.
 */
`default_nettype none

package ram_playback_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // clock and timing
    localparam int SYS_CLK_MHZ = 200;              // system clock rate
    localparam int DDS_DIV = 4;                    // system clocks per DDS clock
    localparam logic [1:0] DDS_DIV_LAST = 2'(DDS_DIV - 1);

    ////////////////////////////////////////////////////////////////////////////
    // widths
    localparam int PROF_N = 8;                     // number of profiles
    localparam int PROF_W = 3;                     // profile select width
    localparam int ADDR_W = 10;                    // RAM address width
    localparam int DATA_W = 32;                    // RAM word width
    localparam int RATE_W = 16;                    // address step rate width
    localparam int MODE_W = 3;                     // mode field width
    localparam int PHASE_W = 16;                   // phase parameter width
    localparam int AMP_W = 14;                     // amplitude parameter width

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int DEST_HI = 30;                   // destination field in first_control_register
    localparam int DEST_LO = 29;
    localparam int PHASE_HI = 31;                  // phase bits of a RAM word
    localparam int PHASE_LO = 16;
    localparam int AMP_HI = 31;                    // amplitude-only bits of a RAM word
    localparam int AMP_LO = 18;
    localparam int POLAR_AMP_HI = 15;              // amplitude bits in polar
    localparam int POLAR_AMP_LO = 2;

    ////////////////////////////////////////////////////////////////////////////
    // reset values and the unit rate
    localparam logic [ADDR_W-1:0] ADDR_RST = 10'h000;
    localparam logic [DATA_W-1:0] WORD_RST = 32'h0000_0000;
    localparam logic [PROF_W-1:0] PROF_RST = 3'h0;
    localparam logic [RATE_W-1:0] RATE_ONE = 16'h0001;

    ////////////////////////////////////////////////////////////////////////////
    // destination codes
    localparam logic [1:0] DEST_FREQ = 2'h0;
    localparam logic [1:0] DEST_PHASE = 2'h1;
    localparam logic [1:0] DEST_AMP = 2'h2;
    localparam logic [1:0] DEST_POLAR = 2'h3;

    // decoded playback modes
    typedef enum logic [2:0] {
        MK_DIRECT = 3'b000,
        MK_RAMP_UP = 3'b001,
        MK_BIDIR = 3'b010,
        MK_CONT_BIDIR = 3'b011,
        MK_RECIRC = 3'b100
    } mode_kind_t;

    // mode field codes
    localparam logic [MODE_W-1:0] MODE_RAMP_UP = 3'h1;
    localparam logic [MODE_W-1:0] MODE_BIDIR = 3'h2;
    localparam logic [MODE_W-1:0] MODE_CONT_BIDIR = 3'h3;
    localparam logic [MODE_W-1:0] MODE_RECIRC = 3'h4;

    // controller states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DIRECT = 3'b001,
        ST_RAMP = 3'b010,
        ST_DONE = 3'b011,
        ST_SUSPEND = 3'b100
    } play_state_t;

endpackage : ram_playback_pkg

`default_nettype wire

// file: ram_step_timer.sv
/*
 * Address step timer: a divide-by-four prescaler forms the DDS clock tick,
 * and a 16-bit counter of those ticks gives one expiry pulse per step rate.
 * Assumes the rate input is stable while the timer runs.
 */
`default_nettype none

module ram_step_timer (
    input wire logic clk_i,                             // system clock
    input wire logic srst_i,                            // synchronous reset, high
    input wire logic restart_i,                         // restart interval from zero
    input wire logic run_i,                             // count while high
    input wire logic [ram_playback_pkg::RATE_W-1:0] rate_i, // step rate in DDS clocks
    output logic expire_o                               // one-cycle expiry pulse
);

    typedef struct packed {
        logic [1:0] pre;
        logic [ram_playback_pkg::RATE_W-1:0] cnt;
        logic expire;
    } timer_state_t;

    timer_state_t s_r;
    timer_state_t s_nxt;
    logic [ram_playback_pkg::RATE_W-1:0] rate_eff;
    logic [ram_playback_pkg::RATE_W-1:0] cnt_inc;

    // a zero rate runs as a rate of one, giving one expiry every DDS clock tick
    assign rate_eff = (rate_i == '0) ? ram_playback_pkg::RATE_ONE : rate_i;
    assign cnt_inc = s_r.cnt + ram_playback_pkg::RATE_ONE;

    ////////////////////////////////////////////////////////////////////////////
    // interval of four system clocks per rate unit
    always_comb begin
        s_nxt = s_r;
        s_nxt.expire = 1'b0;
        if (restart_i || !run_i) begin
            s_nxt.pre = 2'h0;
            s_nxt.cnt = '0;
        end else begin
            s_nxt.pre = s_r.pre + 2'h1;
            if (s_r.pre == ram_playback_pkg::DDS_DIV_LAST) begin
                if (cnt_inc >= rate_eff) begin
                    s_nxt.cnt = '0;
                    s_nxt.expire = 1'b1;
                end else begin
                    s_nxt.cnt = cnt_inc;
                end
            end
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign expire_o = s_r.expire;

endmodule : ram_step_timer

`default_nettype wire

// file: ram_playback_monitor.sv
/* port checker for the RAM playback controller.
   assumes one clock and the design's synchronous active-high reset. */
`default_nettype none

module ram_playback_monitor (
    input wire logic clk_i, // system clock
    input wire logic srst_i, // sync reset
    input wire logic ram_enable_i, // enable bit
    input wire logic io_update_i, // start pulse
    input wire logic serial_ram_access_i, // serial owns RAM
    input wire logic [2:0] profile_i, // profile pins
    input wire logic [23:0] mode_i, // mode fields
    input wire logic [9:0] ram_addr_o, // RAM address
    input wire logic ram_rd_o, // read strobe
    input wire logic sweep_done_out_o, // sweep done
    input wire logic playing_o // busy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);
    ////////////////////////////////////////
    logic [2:0] calm_r, prof_r, sel_mode;
    assign sel_mode = mode_i[3*profile_i+:3];
    // a start reloads the address, so steps are judged only well clear of one
    always_ff @(posedge clk_i) begin
        prof_r <= profile_i;
        if (srst_i || io_update_i || serial_ram_access_i || profile_i != prof_r) calm_r <= 3'h0;
        else if (calm_r != 3'h7) calm_r <= calm_r + 3'h1;
    end
    sequence addr_step;
        calm_r == 3'h7 && playing_o && ram_addr_o != $past(ram_addr_o);
    endsequence
    chk_serial_no_read: assert property (serial_ram_access_i |-> !ram_rd_o)
        else $error("read strobe during serial access");
    chk_serial_drop_flag: assert property (serial_ram_access_i |=> !sweep_done_out_o)
        else $error("sweep done kept during serial access");
    chk_start_clear_flag: assert property (io_update_i && !serial_ram_access_i |=> !sweep_done_out_o)
        else $error("start left sweep done high");
    chk_disabled_idle: assert property (io_update_i && !serial_ram_access_i && !ram_enable_i |=>
        (!playing_o && !sweep_done_out_o)[*3]) else $error("playback while disabled");
    chk_flag_after_play: assert property ($rose(sweep_done_out_o) |-> $past(playing_o))
        else $error("sweep done without playback");
    chk_step_by_one: assert property (addr_step |-> ram_addr_o == $past(ram_addr_o) + 10'h001)
        else $error("address step not one");
    chk_step_spacing: assert property (addr_step |=> $stable(ram_addr_o)[*3])
        else $error("address stepped faster than four clocks");
    chk_direct_no_flag: assert property (io_update_i && (sel_mode == 3'h0 || sel_mode > 3'h4) |=>
        (!sweep_done_out_o)[*8]) else $error("sweep done in direct switch");
endmodule : ram_playback_monitor

bind ram_waveform_playback ram_playback_monitor u_ram_playback_monitor (.clk_i, .srst_i, .ram_enable_i,
    .io_update_i, .serial_ram_access_i, .profile_i, .mode_i, .ram_addr_o, .ram_rd_o, .sweep_done_out_o, .playing_o);

`default_nettype wire

// file: dds_core_model.sv
/* far side model: waveform RAM with one cycle of read latency and a phase
   accumulator that wraps every fourth clock while the bench lets it run. */
`default_nettype none

module dds_core_model (
    input wire logic clk_i, // system clock
    input wire logic srst_i, // sync reset
    input wire logic [9:0] addr_i, // read address
    input wire logic rd_i, // read strobe
    input wire logic run_i, // accumulator advances
    output logic [31:0] data_o, // RAM word
    output logic wrap_o // accumulator rolled over
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] acc_r;
    ////////////////////////////////////////
    // contents follow the address; an idle port flips its bits so stale data is never mistaken
    always_ff @(posedge clk_i) begin
        data_o <= rd_i ? {~addr_i, addr_i, addr_i, 2'h1} : ~data_o;
        acc_r <= srst_i ? 2'h0 : acc_r + {1'b0, run_i};
    end
    assign wrap_o = run_i && acc_r == 2'h3;
endmodule : dds_core_model

`default_nettype wire

// file: ram_waveform_playback_tb_top.sv
/* self-checking bench for the RAM playback controller.
   assumes the far side model and the port checker bound to the design. */
`default_nettype none

module ram_waveform_playback_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, srst_i = 1'b1, ram_enable_i = 1'b1, io_update_i = 1'b0, serial_ram_access_i = 1'b0;
    logic run = 1'b0, phase_wrap_i, ram_rd_o, sweep_done_out_o, playing_o, unsupported_mode_o;
    logic [2:0] profile_i = 3'h0;
    logic [31:0] first_control_register_i = 32'h0000_0000, frequency_tuning_word_i = 32'h1234_5678;
    logic [15:0] phase_offset_word_i = 16'hBEEF, phase_o;
    logic [13:0] amplitude_scale_factor_i = 14'h2AAA, amp_o;
    // end above start everywhere; profiles 1, 2 no-dwell, 2 zero crossing, 1 steps every twelve clocks
    logic [79:0] start_addr_i = {10'h000, 10'h014, 30'h0, 10'h009, 10'h002, 10'h005};
    logic [79:0] end_addr_i = {60'hFFFF_FFFF_FFFF_FFF, 10'h004, 10'h008};
    logic [127:0] step_rate_i = {{6{16'h0001}}, 16'h0003, 16'h0001};
    logic [23:0] mode_i = {3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h0, 3'h1, 3'h1};
    logic [7:0] no_dwell_i = 8'h06, zero_cross_i = 8'h04;
    logic [9:0] ram_addr_o;
    logic [31:0] ram_data_i, freq_o, w;
    int mismatches = 0, samples_checked = 0;
    ////////////////////////////////////////
    initial forever #2.5 clk_i = ~clk_i;
    ram_waveform_playback u_ram_waveform_playback (.clk_i, .srst_i, .ram_enable_i, .io_update_i,
        .serial_ram_access_i, .profile_i, .first_control_register_i, .start_addr_i, .end_addr_i, .step_rate_i,
        .mode_i, .no_dwell_i, .zero_cross_i, .frequency_tuning_word_i, .phase_offset_word_i,
        .amplitude_scale_factor_i, .phase_wrap_i, .ram_data_i, .ram_addr_o, .ram_rd_o, .freq_o, .phase_o,
        .amp_o, .sweep_done_out_o, .playing_o, .unsupported_mode_o);
    dds_core_model u_dds_core_model (.clk_i, .srst_i, .addr_i(ram_addr_o), .rd_i(ram_rd_o), .run_i(run),
        .data_o(ram_data_i), .wrap_o(phase_wrap_i));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : step
    task automatic pulse_update();
        @(posedge clk_i) io_update_i <= 1'b1;
        @(posedge clk_i) io_update_i <= 1'b0;
    endtask : pulse_update
    // bounded wait, so a flag that never rises shows up as a mismatch rather than a hang
    task automatic wait_done();
        for (int n = 0; n < 200 && sweep_done_out_o !== 1'b1; n++) step(1);
    endtask : wait_done
    task automatic set_prof(input logic [2:0] p);
        @(posedge clk_i) profile_i <= p;
        step(14);
        w = {~start_addr_i[10*p+:10], start_addr_i[10*p+:10], start_addr_i[10*p+:10], 2'h1};
    endtask : set_prof
    task automatic finish_test();
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    // a full run is about three hundred clocks
    initial begin
        #100000;
        mismatches++;
        finish_test();
    end
    // ramp, no-dwell ramp, direct, zero crossing, routing, unsupported modes, serial abort, disable
    initial begin
        repeat (20) @(posedge clk_i);
        srst_i <= 1'b0;
        pulse_update();
        wait_done();
        check(ram_addr_o, 10'h008);
        step(6);
        check(sweep_done_out_o, 1'b1);
        check(freq_o, {~10'h008, 10'h008, 10'h008, 2'h1});
        @(posedge clk_i) first_control_register_i <= 32'h2000_0000;
        profile_i <= 3'h1;
        step(16);
        check({sweep_done_out_o, ram_addr_o}, {1'b0, 10'h003});
        wait_done();
        check(ram_addr_o, 10'h002);
        set_prof(3'h6);
        check(ram_addr_o, 10'h014);
        check(phase_o, w[31:16]);
        check(sweep_done_out_o, 1'b0);
        check(freq_o, frequency_tuning_word_i);
        set_prof(3'h2);
        check(phase_o, {~10'h014, 6'h01});
        @(posedge clk_i) run <= 1'b1;
        step(8);
        check(phase_o, w[31:16]);
        for (int d = 2; d < 4; d++) begin
            @(posedge clk_i) first_control_register_i <= 32'(d) << 29;
            pulse_update();
            step(10);
            check(amp_o, (d == 2) ? w[31:18] : w[15:2]);
            check(phase_o, (d == 2) ? phase_offset_word_i : w[31:16]);
        end
        for (int p = 3; p < 8; p++) begin
            set_prof(3'(p));
            check(unsupported_mode_o, 32'(p < 6));
        end
        @(posedge clk_i) first_control_register_i <= 32'h0000_0000;
        profile_i <= 3'h0;
        step(8);
        @(posedge clk_i) serial_ram_access_i <= 1'b1;
        step(6);
        check(ram_rd_o, 1'b0);
        check(freq_o, frequency_tuning_word_i);
        @(posedge clk_i) serial_ram_access_i <= 1'b0;
        step(30);
        check(sweep_done_out_o, 1'b0);
        pulse_update();
        @(posedge clk_i) ram_enable_i <= 1'b0;
        wait_done();
        check(sweep_done_out_o, 1'b1);
        pulse_update();
        step(8);
        check({playing_o, sweep_done_out_o}, 2'h0);
        check(freq_o, frequency_tuning_word_i);
        finish_test();
    end
endmodule : ram_waveform_playback_tb_top

`default_nettype wire
